/* File: verilog/occ_consts.vh */
// Purpose: Constants for the output compare channel.
// Assumes: 16-bit registers on a plain strobe port.
// Notes: Offsets are word indices on the register port.
`ifndef OCC_CONSTS_VH
`define OCC_CONSTS_VH
`define OCC_ADDR_W 3
`define OCC_ADDR_CON1 3'h0
`define OCC_ADDR_PRI 3'h1
`define OCC_ADDR_SEC 3'h2
`define OCC_ADDR_TMR 3'h3
`define OCC_ADDR_CON2 3'h4
`define OCC_CON1_RESET 16'h0000
`define OCC_CON1_WMASK 16'h3dbf
`define OCC_CON2_RESET 16'h0000
`define OCC_BIT_SIDL 13
`define OCC_BIT_TSEL_HI 12
`define OCC_BIT_TSEL_LO 10
`define OCC_BIT_ENFB 8
`define OCC_BIT_ENFA 7
`define OCC_BIT_FLTB 5
`define OCC_BIT_FLTA 4
`define OCC_BIT_TRGM 3
`define OCC_BIT_MODE_HI 2
`define OCC_BIT_MODE_LO 0
`define OCC_BIT_FAULT_OUTPUT_LEVEL 14
`define OCC_BIT_TSTAT 6
`define OCC_MODE_OFF 3'h0
`define OCC_MODE_SS_HI 3'h1
`define OCC_MODE_SS_LO 3'h2
`define OCC_MODE_TOG 3'h3
`define OCC_MODE_DSS 3'h4
`define OCC_MODE_DCONT 3'h5
`define OCC_MODE_EPWM 3'h6
`define OCC_MODE_CPWM 3'h7
`define OCC_TSEL_RSVD 3'h6
`endif

/* File: verilog/occ_sync.v */
// Purpose: Two-flop synchroniser and rising-edge detect for external inputs.
// Assumes: Inputs are asynchronous to MCLK_I.
// Notes: Edge detect reads only the second and third flops.
`timescale 1ns/1ps
`include "occ_consts.vh"
module occ_sync #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign level_o = s2_q;
  assign rise_o = s2_q & ~s3_q;
endmodule

/* File: verilog/occ_channel.v */
// Purpose: One output compare channel with timer, two compare registers and faults.
// Assumes: Clock sources, trigger and fault pins arrive asynchronous; registers are 16 bits.
// Notes: Read data appear the cycle after the read strobe.
// Notes: Compare reads show the buffered value in PWM modes; timer reads are live.
// Summary of operation
// - Three-bit select picks timer clock: peripheral, trigger generator, timer one..five.
// - With idle-stop set, channel halts while processor idles; otherwise runs.
// - Fault B input is honoured only while its enable bit is one.
// - Fault A input is honoured only while its enable bit is one.
// - Fault flags set by hardware on fault in PWM modes; software may also write them.
// - Auto-clear mode clears trigger status on timer equal secondary register.
// - Center PWM: high at primary match, low at secondary match.
// - Edge PWM: high at timer zero, low at primary match.
// - Double continuous: start low, toggle on alternating primary and secondary matches.
// - Double single-shot: start low, toggle on primary then secondary, one pulse.
// - Single compare toggle: toggle on every primary match, continuously.
// - Single-shot low: start high, forced low on first primary match.
// - Single-shot high: start low, forced high on first primary match.
// - Mode zero disables the channel; output stays inactive.
// - Compare registers double-buffered in PWM modes, direct otherwise.
// - Timer compared with one or two registers; output changes on match.
// - Compare match raises interrupt request and DMA request pulses.
// - Trigger status one while timer runs; zero holds timer at zero.
// - During fault, PWM output driven to the fault output level bit.
`timescale 1ns/1ps
`include "occ_consts.vh"
module occ_channel #(
  parameter TW = 16
) (
  input wire MCLK_I,
  input wire RST_I,
  input wire [`OCC_ADDR_W-1:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [15:0] RDATA_O,
  input wire [4:0] TMR_CLK_I,
  input wire PTG_CLK_I,
  input wire TRIG_I,
  input wire CPU_IDLE_I,
  input wire FAULT_A_I,
  input wire FAULT_B_I,
  output reg OC_PIN_O,
  output reg IRQ_O,
  output reg DMA_REQ_O
);
  // Sources: [4:0] timers 2..5 and 1, [5] trigger-generator clock, [6] trigger, [7:8] faults
  // Each source level must hold for longer than one system clock or its edge may be lost
  // Edges are taken behind the synchroniser, so ticks lag the pin by two clocks
  wire [8:0] sync_lvl;
  wire [8:0] sync_rise;
  occ_sync #(.W(9)) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .async_i({FAULT_B_I, FAULT_A_I, TRIG_I, PTG_CLK_I, TMR_CLK_I}),
    .level_o(sync_lvl),
    .rise_o(sync_rise)
  );

  reg [15:0] con1_q;
  reg [15:0] con2_q;
  reg [TW-1:0] pri_q;
  reg [TW-1:0] sec_q;
  reg [TW-1:0] pri_buf_q;
  reg [TW-1:0] sec_buf_q;
  reg [TW-1:0] tmr_q;
  reg oc_q;
  reg armed_q;
  reg phase_q;
  reg [2:0] mode_prev_q;

  wire [2:0] mode = con1_q[`OCC_BIT_MODE_HI:`OCC_BIT_MODE_LO];
  wire [2:0] tsel = con1_q[`OCC_BIT_TSEL_HI:`OCC_BIT_TSEL_LO];
  wire is_pwm = (mode == `OCC_MODE_EPWM) || (mode == `OCC_MODE_CPWM);
  wire running = con2_q[`OCC_BIT_TSTAT];
  // Idle comes from the processor on this clock, so it is not synchronised
  wire halted = con1_q[`OCC_BIT_SIDL] & CPU_IDLE_I;
  wire flt_a = sync_lvl[7] & con1_q[`OCC_BIT_ENFA];
  wire flt_b = sync_lvl[8] & con1_q[`OCC_BIT_ENFB];
  // A set flag keeps the override after the pin clears, until software writes zero
  wire fault_on = flt_a | flt_b | con1_q[`OCC_BIT_FLTA] | con1_q[`OCC_BIT_FLTB];

  // Decodes the clock select into a one-cycle count enable
  // The reserved code never ticks, so a stray write only freezes the timer
  function tick_sel;
    input [2:0] sel;
    input [8:0] rise;
    begin
      case (sel)
        3'h7: tick_sel = 1'b1;
        `OCC_TSEL_RSVD: tick_sel = 1'b0;
        3'h5: tick_sel = rise[5];
        3'h4: tick_sel = rise[4];
        3'h3: tick_sel = rise[3];
        3'h2: tick_sel = rise[2];
        3'h1: tick_sel = rise[1];
        default: tick_sel = rise[0];
      endcase
    end
  endfunction

  wire tick = tick_sel(tsel, sync_rise) & ~halted & running;
  wire match_pri = (tmr_q == pri_q);
  wire match_sec = (tmr_q == sec_q);
  wire match_zero = (tmr_q == {TW{1'b0}});
  wire active = (mode != `OCC_MODE_OFF) && !halted;
  wire evt = active & tick;

  wire wr_con1 = WR_I && (ADDR_I == `OCC_ADDR_CON1);
  wire wr_con2 = WR_I && (ADDR_I == `OCC_ADDR_CON2);
  wire wr_pri = WR_I && (ADDR_I == `OCC_ADDR_PRI);
  wire wr_sec = WR_I && (ADDR_I == `OCC_ADDR_SEC);
  wire mode_change = (mode != mode_prev_q);
  // Both PWM modes roll the timer over on the secondary match, so buffers load there
  wire period_end = is_pwm && evt && match_sec;
  // Interrupt and transfer requests share one term so they can never disagree
  wire sec_counts = (mode >= `OCC_MODE_DSS);
  wire match_req = evt && (match_pri || (match_sec && sec_counts));

  // Control register 1 with hardware-set fault flags; set wins over a write
  // Flags are set only while a PWM mode is selected; software clears them by writing zero
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      con1_q <= `OCC_CON1_RESET;
    end else begin
      if (wr_con1) begin
        con1_q <= WDATA_I & `OCC_CON1_WMASK;
      end
      if (flt_a && is_pwm) begin
        con1_q[`OCC_BIT_FLTA] <= 1'b1;
      end
      if (flt_b && is_pwm) begin
        con1_q[`OCC_BIT_FLTB] <= 1'b1;
      end
    end
  end

  // Control register 2: fault output level and trigger status
  // A trigger edge outranks a software or automatic clear in the same cycle
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      con2_q <= `OCC_CON2_RESET;
    end else begin
      if (wr_con2) begin
        con2_q[`OCC_BIT_FAULT_OUTPUT_LEVEL] <= WDATA_I[`OCC_BIT_FAULT_OUTPUT_LEVEL];
        con2_q[`OCC_BIT_TSTAT] <= WDATA_I[`OCC_BIT_TSTAT];
      end else if (con1_q[`OCC_BIT_TRGM] && evt && match_sec && running) begin
        con2_q[`OCC_BIT_TSTAT] <= 1'b0;
      end
      if (sync_rise[6]) begin
        con2_q[`OCC_BIT_TSTAT] <= 1'b1;
      end
    end
  end

  // Compare registers: in PWM modes writes land in a buffer taken at period end
  // The buffer takes every write, so a later switch into PWM starts from it
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      pri_q <= {TW{1'b0}};
      sec_q <= {TW{1'b0}};
      pri_buf_q <= {TW{1'b0}};
      sec_buf_q <= {TW{1'b0}};
    end else begin
      if (wr_pri) begin
        pri_buf_q <= WDATA_I[TW-1:0];
      end
      if (wr_sec) begin
        sec_buf_q <= WDATA_I[TW-1:0];
      end
      if (!is_pwm) begin
        if (wr_pri) begin
          pri_q <= WDATA_I[TW-1:0];
        end
        if (wr_sec) begin
          sec_q <= WDATA_I[TW-1:0];
        end
      end else if (period_end || !running) begin
        pri_q <= pri_buf_q;
        sec_q <= sec_buf_q;
      end
    end
  end

  // In PWM and double continuous modes the timer rolls over on secondary match, so the secondary register sets the period
  // Other modes run on to the natural wrap of the counter
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      tmr_q <= {TW{1'b0}};
    end else if (mode == `OCC_MODE_OFF || !running) begin
      tmr_q <= {TW{1'b0}};
    end else if (tick) begin
      if (match_sec && (is_pwm || mode == `OCC_MODE_DCONT)) begin
        tmr_q <= {TW{1'b0}};
      end else begin
        tmr_q <= tmr_q + {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Output waveform per mode
  // A mode write re-initialises the level before any match is honoured
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      oc_q <= 1'b0;
      armed_q <= 1'b0;
      phase_q <= 1'b0;
      mode_prev_q <= `OCC_MODE_OFF;
    end else begin
      mode_prev_q <= mode;
      if (mode_change) begin
        oc_q <= (mode == `OCC_MODE_SS_LO);
        armed_q <= 1'b1;
        phase_q <= 1'b0;
      end else if (evt) begin
        case (mode)
          `OCC_MODE_SS_HI: begin
            if (armed_q && match_pri) begin
              oc_q <= 1'b1;
              armed_q <= 1'b0;
            end
          end
          `OCC_MODE_SS_LO: begin
            if (armed_q && match_pri) begin
              oc_q <= 1'b0;
              armed_q <= 1'b0;
            end
          end
          `OCC_MODE_TOG: begin
            if (match_pri) begin
              oc_q <= ~oc_q;
            end
          end
          `OCC_MODE_DSS, `OCC_MODE_DCONT: begin
            if (armed_q && !phase_q && match_pri) begin
              oc_q <= 1'b1;
              phase_q <= 1'b1;
            end else if (armed_q && phase_q && match_sec) begin
              oc_q <= 1'b0;
              phase_q <= 1'b0;
              armed_q <= (mode == `OCC_MODE_DCONT);
            end
          end
          `OCC_MODE_EPWM: begin
            if (match_pri) begin
              oc_q <= 1'b0;
            end else if (match_zero) begin
              oc_q <= 1'b1;
            end
          end
          `OCC_MODE_CPWM: begin
            if (match_sec) begin
              oc_q <= 1'b0;
            end else if (match_pri) begin
              oc_q <= 1'b1;
            end
          end
          default: begin
            oc_q <= 1'b0;
          end
        endcase
      end else if (mode == `OCC_MODE_OFF) begin
        oc_q <= 1'b0;
      end
    end
  end

  // Pin, fault override and match requests, all registered
  // Fault override applies only in PWM modes; other modes keep their waveform
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      OC_PIN_O <= 1'b0;
      IRQ_O <= 1'b0;
      DMA_REQ_O <= 1'b0;
    end else begin
      if (is_pwm && fault_on) begin
        OC_PIN_O <= con2_q[`OCC_BIT_FAULT_OUTPUT_LEVEL];
      end else begin
        OC_PIN_O <= oc_q;
      end
      IRQ_O <= match_req;
      DMA_REQ_O <= match_req;
    end
  end

  // Read port; unmapped addresses read zero
  // Compare reads show the buffer in PWM modes, so software sees its last write
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        `OCC_ADDR_CON1: RDATA_O <= con1_q;
        `OCC_ADDR_PRI: RDATA_O <= {{(16-TW){1'b0}}, is_pwm ? pri_buf_q : pri_q};
        `OCC_ADDR_SEC: RDATA_O <= {{(16-TW){1'b0}}, is_pwm ? sec_buf_q : sec_q};
        `OCC_ADDR_TMR: RDATA_O <= {{(16-TW){1'b0}}, tmr_q};
        `OCC_ADDR_CON2: RDATA_O <= con2_q;
        default: RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end
endmodule

/* File: bench/occ_asserts.sv */
// Purpose: Port checks for the compare channel.
// Assumes: Mode and fault settings are shadowed from bus writes.
// Notes: Output lags a write by two cycles, so windows start late.
`timescale 1ns/1ps
module occ_asserts (
  input wire MCLK_I,
  input wire RST_I,
  input wire [2:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [15:0] RDATA_O,
  input wire CPU_IDLE_I,
  input wire FAULT_A_I,
  input wire OC_PIN_O,
  input wire IRQ_O,
  input wire DMA_REQ_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  logic [15:0] con1_q;
  logic lvl_q;
  wire [2:0] mode = con1_q[2:0];
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      con1_q <= 16'h0000;
      lvl_q <= 1'b0;
    end else if (WR_I && ADDR_I == 3'h0) begin
      con1_q <= WDATA_I;
    end else if (WR_I && ADDR_I == 3'h4) begin
      lvl_q <= WDATA_I[14];
    end
  end
  sequence s_hold(m);
    (mode == m)[*4];
  endsequence
  sequence s_fault;
    (FAULT_A_I && con1_q[7] && mode[2:1] == 2'b11 && !lvl_q)[*6];
  endsequence
  AST_OFF_QUIET: assert property (s_hold(3'h0) |-> !OC_PIN_O && !IRQ_O)
    else $error("output active while channel off");
  AST_IRQ_DMA: assert property (IRQ_O == DMA_REQ_O)
    else $error("interrupt and dma requests differ");
  AST_IRQ_PULSE: assert property (IRQ_O |=> !IRQ_O)
    else $error("match request longer than one cycle");
  AST_SS_HIGH: assert property (s_hold(3'h1) ##0 OC_PIN_O |=> OC_PIN_O)
    else $error("single shot high output fell");
  AST_SS_LOW: assert property (s_hold(3'h2) ##0 !OC_PIN_O |=> !OC_PIN_O)
    else $error("single shot low output rose");
  AST_FAULT_LOW: assert property (s_fault |-> !OC_PIN_O)
    else $error("output not at fault level");
  AST_IDLE_HALT: assert property ((CPU_IDLE_I && con1_q[13] && $stable(con1_q))[*5]
    |-> !IRQ_O && $stable(OC_PIN_O))
    else $error("channel active while idle halted");
  AST_CON1_RSVD: assert property (RD_I && ADDR_I == 3'h0 |=> (RDATA_O & 16'hc240) == 0)
    else $error("unimplemented control bits read nonzero");
endmodule

/* File: bench/occ_pin_load.sv */
// Purpose: Load on the compare output that counts rising edges.
// Assumes: Push-pull pin sampled on the system clock.
// Notes: The bench clears the count before each mode test and before the fault test.
`timescale 1ns/1ps
module occ_pin_load (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic pin_i,
  output logic [7:0] rise_o
);
  logic last_q;
  always @(posedge clk_i) begin
    last_q <= pin_i;
    if (clr_i) begin
      rise_o <= 8'h00;
    end else if (pin_i && !last_q && rise_o != 8'hff) begin
      rise_o <= rise_o + 8'h01;
    end
  end
endmodule

/* File: bench/occ_channel_tb.sv */
// Purpose: Self-checking bench for the compare channel.
// Assumes: Clock select 111 counts every system clock.
// Notes: Reads are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module occ_channel_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_q = 0, pclk = 0, trig = 0;
  logic idle = 0, fa = 0, fb = 0, clr = 1;
  logic [2:0] addr = 0;
  logic [15:0] wdata = 0;
  logic [4:0] tclk = 0;
  wire [15:0] rdata;
  wire pin, irq, dma;
  wire [7:0] rises;
  logic [7:0] irqs = 8'h00, dmas = 8'h00;
  logic [7:0] exp_i [5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h02};
  logic [15:0] expq[$];
  logic [7:0] exp_r [5] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h01};
  logic exp_p [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int num_errors = 0, check_count = 0, seed = 58, n;
  always #2.5 clk = ~clk;
  occ_channel DUT (.MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TMR_CLK_I(tclk), .PTG_CLK_I(pclk),
    .TRIG_I(trig), .CPU_IDLE_I(idle), .FAULT_A_I(fa), .FAULT_B_I(fb),
    .OC_PIN_O(pin), .IRQ_O(irq), .DMA_REQ_O(dma));
  occ_pin_load u_load (.clk_i(clk), .clr_i(clr), .pin_i(pin), .rise_o(rises));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wrr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [2:0] a, input logic [15:0] e);
    expq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic arm;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) begin
      chk(rdata, expq.pop_front());
    end
  end
  // Match requests are counted per test; the load clear also clears them
  always @(posedge clk) begin
    if (clr) begin
      irqs <= 8'h00;
      dmas <= 8'h00;
    end else begin
      irqs <= irqs + {7'h00, irq};
      dmas <= dmas + {7'h00, dma};
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    rdx(3'h0, 16'h0000);
    rdx(3'h5, 16'h0000);
    // Keep compares away from the held timer so mode 111 stays quiet
    wrr(3'h1, 16'h1234);
    wrr(3'h2, 16'h1234);
    rdx(3'h2, 16'h1234);
    wrr(3'h0, 16'hffff);
    rdx(3'h0, 16'h3dbf);
    $display("register test done");
    for (int s = 0; s < 6; s++) begin
      n = 1 + ($unsigned($random(seed)) % 8);
      wrr(3'h0, 16'h0000);
      wrr(3'h1, 16'hffff);
      wrr(3'h0, {3'h0, s[2:0], 10'h003});
      wrr(3'h4, 16'h0040);
      repeat (n) begin
        if (s < 5) begin
          tclk[s] <= 1'b1;
        end else begin
          pclk <= 1'b1;
        end
        cyc(4);
        tclk <= 5'h00;
        pclk <= 1'b0;
        cyc(4);
      end
      rdx(3'h3, 16'(n));
    end
    $display("clock select test done");
    for (int m = 0; m < 8; m++) begin
      wrr(3'h0, 16'h0000);
      wrr(3'h4, 16'h0000);
      wrr(3'h1, 16'h0004);
      wrr(3'h2, 16'h0009);
      wrr(3'h0, {6'h07, 7'h00, m[2:0]});
      cyc(6);
      arm;
      trig <= 1'b1;
      cyc(60);
      trig <= 1'b0;
      if (m >= 5) begin
        chk({15'h0, rises >= 8'h02}, 16'h0001);
        chk({15'h0, irqs >= 8'h02}, 16'h0001);
      end else begin
        chk({8'h00, rises}, {8'h00, exp_r[m]});
        chk({15'h0, pin}, {15'h0, exp_p[m]});
        chk({8'h00, irqs}, {8'h00, exp_i[m]});
        chk({8'h00, dmas}, {8'h00, exp_i[m]});
      end
    end
    $display("mode test done");
    wrr(3'h0, 16'h0000);
    wrr(3'h4, 16'h0000);
    fa <= 1'b1;
    fb <= 1'b1;
    wrr(3'h0, 16'h1c86);
    arm;
    wrr(3'h4, 16'h0040);
    cyc(60);
    chk({8'h00, rises}, 16'h0000);
    rdx(3'h0, 16'h1c96);
    fa <= 1'b0;
    fb <= 1'b0;
    $display("fault test done");
    wrr(3'h0, 16'h0000);
    idle <= 1'b1;
    wrr(3'h0, 16'h3c03);
    wrr(3'h4, 16'h0040);
    cyc(20);
    rdx(3'h3, 16'h0000);
    idle <= 1'b0;
    wrr(3'h0, 16'h0000);
    wrr(3'h0, 16'h1c0b);
    wrr(3'h4, 16'h0040);
    cyc(30);
    rdx(3'h4, 16'h0000);
    rdx(3'h3, 16'h0000);
    wrr(3'h0, 16'h0000);
    wrr(3'h0, 16'h1c03);
    wrr(3'h4, 16'h0040);
    cyc(30);
    rdx(3'h4, 16'h0040);
    cyc(3);
    $display("idle and trigger test done");
    test_done;
  end
endmodule
bind occ_channel occ_asserts u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .CPU_IDLE_I(CPU_IDLE_I), .FAULT_A_I(FAULT_A_I), .OC_PIN_O(OC_PIN_O),
  .IRQ_O(IRQ_O), .DMA_REQ_O(DMA_REQ_O));
